// ==== tfpp_pkg.sv ====
// Constants and types for the 16-bit fast and phase correct PWM timer
`default_nettype none
package tfpp_pkg;
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int NUM_CH    = 2;
  localparam int NUM_FLAGS = 4;
  localparam int PRESC_W   = 10;

  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COMPARE_A = 8'h04;
  localparam logic [ADDR_W-1:0] CH_STRIDE     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNTER   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DIR       = 8'h1C;

  localparam int CTRL_WMS_LSB = 0;
  localparam int CTRL_CS_LSB  = 4;
  localparam int CTRL_ACT_LSB = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;

  localparam logic [3:0] WMS_PC8      = 4'h1;
  localparam logic [3:0] WMS_PC9      = 4'h2;
  localparam logic [3:0] WMS_PC10     = 4'h3;
  localparam logic [3:0] WMS_FP8      = 4'h5;
  localparam logic [3:0] WMS_FP9      = 4'h6;
  localparam logic [3:0] WMS_FP10     = 4'h7;
  localparam logic [3:0] WMS_PC_CAP   = 4'hA;
  localparam logic [3:0] WMS_PC_CMPA  = 4'hB;
  localparam logic [3:0] WMS_FP_CAP   = 4'hE;
  localparam logic [3:0] WMS_FP_CMPA  = 4'hF;

  localparam logic [DATA_W-1:0] TOP_8   = 16'h00FF;
  localparam logic [DATA_W-1:0] TOP_9   = 16'h01FF;
  localparam logic [DATA_W-1:0] TOP_10  = 16'h03FF;
  localparam logic [DATA_W-1:0] MAX_VAL = 16'hFFFF;
  localparam logic [DATA_W-1:0] BOTTOM  = 16'h0000;

  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [PRESC_W-1:0] MASK_DIV8    = 10'h007;
  localparam logic [PRESC_W-1:0] MASK_DIV64   = 10'h03F;
  localparam logic [PRESC_W-1:0] MASK_DIV256  = 10'h0FF;
  localparam logic [PRESC_W-1:0] MASK_DIV1024 = 10'h3FF;

  localparam int FLAG_OVF  = 0;
  localparam int FLAG_CMPA = 1;
  localparam int FLAG_CMPB = 2;
  localparam int FLAG_CAP  = 3;

  typedef enum logic {
    TFPP_UP   = 1'b0,
    TFPP_DOWN = 1'b1
  } tfpp_dir_t;
endpackage
`default_nettype wire

// ==== tfpp_timer.sv ====
// Fast and phase correct PWM timer with register port and pin outputs
`default_nettype none
module tfpp_timer
  import tfpp_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [ADDR_W-1:0]    addr,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [DATA_W-1:0]    rdata,
  output logic      [NUM_CH-1:0]    pin_out,
  output logic      [NUM_CH-1:0]    pin_oe,
  output logic      [NUM_FLAGS-1:0] irq_req,
  input  wire logic [NUM_FLAGS-1:0] irq_ack
);

  logic [DATA_W-1:0]    ctrl;
  logic [DATA_W-1:0]    capture_value;
  logic [DATA_W-1:0]    counter_value;
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] irq_en;
  logic [NUM_CH-1:0]    pin_direction_bit;
  logic [PRESC_W-1:0]   presc;
  tfpp_dir_t            dir;
  tfpp_dir_t            next_dir;

  logic [DATA_W-1:0]    compare_value [NUM_CH];
  logic [DATA_W-1:0]    cmp_buf [NUM_CH];
  logic [NUM_CH-1:0]    match;
  logic [NUM_CH-1:0]    compare_output;

  logic [3:0]           waveform_mode_select;
  logic [2:0]           clk_sel;
  logic                 is_fast;
  logic                 is_phase;
  logic                 fixed_top;
  logic                 top_is_cap;
  logic                 top_is_cmpa;
  logic [DATA_W-1:0]    top;
  logic [DATA_W-1:0]    wr_mask;
  logic                 tick;
  logic                 at_top;
  logic                 at_bot;
  logic                 going_up;
  logic                 load_evt;
  logic                 ovf_evt;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;

  assign waveform_mode_select = ctrl[CTRL_WMS_LSB +: 4];
  assign clk_sel              = ctrl[CTRL_CS_LSB +: 3];

  // Mode decode and top selection
  // Unused mode codes count up freely to 0xFFFF
  always_comb begin
    is_fast     = 1'b0;
    is_phase    = 1'b0;
    fixed_top   = 1'b0;
    top_is_cap  = 1'b0;
    top_is_cmpa = 1'b0;
    top         = MAX_VAL;
    case (waveform_mode_select)
      WMS_PC8, WMS_FP8: begin
        top       = TOP_8;
        fixed_top = 1'b1;
      end
      WMS_PC9, WMS_FP9: begin
        top       = TOP_9;
        fixed_top = 1'b1;
      end
      WMS_PC10, WMS_FP10: begin
        top       = TOP_10;
        fixed_top = 1'b1;
      end
      WMS_PC_CAP, WMS_FP_CAP: begin
        top        = capture_value;
        top_is_cap = 1'b1;
      end
      WMS_PC_CMPA, WMS_FP_CMPA: begin
        top         = compare_value[0];
        top_is_cmpa = 1'b1;
      end
      default: top = MAX_VAL;
    endcase
    case (waveform_mode_select)
      WMS_FP8, WMS_FP9, WMS_FP10, WMS_FP_CAP, WMS_FP_CMPA: is_fast = 1'b1;
      WMS_PC8, WMS_PC9, WMS_PC10, WMS_PC_CAP, WMS_PC_CMPA: is_phase = 1'b1;
      default: is_fast = 1'b0;
    endcase
  end

  assign wr_mask = fixed_top ? top : MAX_VAL;

  // Timer tick from the prescaler
  // Free-running, so a new rate may give a short first tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presc <= '0;
    end else begin
      presc <= presc + 10'h001;
    end
  end

  always_comb begin
    case (clk_sel)
      CS_DIV1:    tick = 1'b1;
      CS_DIV8:    tick = (presc & MASK_DIV8) == MASK_DIV8;
      CS_DIV64:   tick = (presc & MASK_DIV64) == MASK_DIV64;
      CS_DIV256:  tick = (presc & MASK_DIV256) == MASK_DIV256;
      CS_DIV1024: tick = presc == MASK_DIV1024;
      default:    tick = 1'b0;
    endcase
  end

  // A top below the count is missed until the counter wraps
  assign at_top = counter_value == top;
  assign at_bot = counter_value == BOTTOM;

  // Slope seen by a match; bottom counts as rising, top as falling
  assign going_up = at_bot ? 1'b1 : (at_top ? 1'b0 : (dir == TFPP_UP));

  // Top and bottom each hold for one tick before the turn
  always_comb begin
    next_dir = dir;
    if (at_top) begin
      next_dir = TFPP_DOWN;
    end else if (at_bot) begin
      next_dir = TFPP_UP;
    end
  end

  // Top event: fast mode every top, phase mode top on the rising slope
  assign load_evt = tick & at_top & (is_fast | (is_phase & (dir == TFPP_UP)));

  // Overflow at top in fast mode, at bottom while falling in phase
  always_comb begin
    if (is_fast) begin
      ovf_evt = load_evt;
    end else if (is_phase) begin
      ovf_evt = tick & at_bot & (dir == TFPP_DOWN);
    end else begin
      ovf_evt = tick & (counter_value == MAX_VAL);
    end
  end

  // Counter
  // A software write to the count overrides that cycle's tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_value <= BOTTOM;
      dir           <= TFPP_UP;
    end else if (wr_en && addr == OFS_COUNTER) begin
      counter_value <= wdata;
    end else if (tick) begin
      if (is_fast) begin
        // Clears after top; a missed top wraps through 0xFFFF
        counter_value <= at_top ? BOTTOM : counter_value + 16'h0001;
        dir           <= TFPP_UP;
      end else if (is_phase) begin
        dir <= next_dir;
        if (next_dir == TFPP_UP) begin
          counter_value <= counter_value + 16'h0001;
        end else begin
          counter_value <= counter_value - 16'h0001;
        end
      end else begin
        counter_value <= counter_value + 16'h0001;
        dir           <= TFPP_UP;
      end
    end
  end

  // Compare channels
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [ADDR_W-1:0] CMP_OFS =
      ADDR_W'(OFS_COMPARE_A + CH_STRIDE * i);
    logic [1:0] live_act;
    logic [1:0] eff_act;
    logic [1:0] sel_act;

    assign sel_act = ctrl[CTRL_ACT_LSB + 2*i +: 2];
    assign match[i] = tick & (counter_value == compare_value[i]);
    // Top events use the live copy until the next match
    assign eff_act  = match[i] ? sel_act : live_act;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cmp_buf[i] <= BOTTOM;
      end else if (wr_en && addr == CMP_OFS) begin
        cmp_buf[i] <= wdata & wr_mask;
      end
    end

    // Non-PWM modes follow the buffer; PWM modes load at top
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        compare_value[i] <= BOTTOM;
      end else if (!(is_fast | is_phase) || load_evt) begin
        compare_value[i] <= cmp_buf[i];
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        live_act <= ACT_NONE;
      end else if (match[i]) begin
        live_act <= sel_act;
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        compare_output[i] <= 1'b0;
      end else if (is_fast) begin
        if (match[i] && eff_act == ACT_TOGGLE && i == 0) begin
          compare_output[i] <= ~compare_output[i];
        end else if (load_evt && eff_act[1]) begin
          // Top wins over a match at top: compare equal to top is constant
          compare_output[i] <= (eff_act == ACT_NONINV);
        end else if (match[i] && eff_act[1]) begin
          compare_output[i] <= (eff_act == ACT_INV);
        end
      end else if (is_phase) begin
        if (match[i] && eff_act[1]) begin
          if (going_up) begin
            compare_output[i] <= (eff_act == ACT_INV);
          end else begin
            compare_output[i] <= (eff_act == ACT_NONINV);
          end
        end
      end
    end

    // Level forced low while the pin is an input
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pin_out[i] <= 1'b0;
        pin_oe[i]  <= 1'b0;
      end else begin
        pin_out[i] <= compare_output[i] & pin_direction_bit[i];
        pin_oe[i]  <= pin_direction_bit[i];
      end
    end
  end

  // Flags: a set in the same cycle as a clear wins
  // Clear by service strobe or by writing ones
  always_comb begin
    flag_set            = '0;
    flag_set[FLAG_OVF]  = ovf_evt;
    flag_set[FLAG_CMPA] = match[0] | (load_evt & top_is_cmpa);
    flag_set[FLAG_CMPB] = match[1];
    flag_set[FLAG_CAP]  = load_evt & top_is_cap;
    flag_clr            = irq_ack;
    if (wr_en && addr == OFS_FLAGS) begin
      flag_clr = flag_clr | wdata[NUM_FLAGS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // Request drops in the cycle its flag is cleared
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= flags & irq_en & ~flag_clr;
    end
  end

  // Software registers
  // Writes to unmapped offsets are ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl              <= CTRL_RESET;
      capture_value     <= BOTTOM;
      irq_en            <= '0;
      pin_direction_bit <= '0;
    end else if (wr_en) begin
      case (addr)
        OFS_CTRL:    ctrl <= wdata;
        OFS_CAPTURE: capture_value <= wdata;
        OFS_IRQ_EN:  irq_en <= wdata[NUM_FLAGS-1:0];
        OFS_DIR:     pin_direction_bit <= wdata[NUM_CH-1:0];
        default:     ctrl <= ctrl;
      endcase
    end
  end

  // Read data one cycle after the read strobe, else zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      case (addr)
        OFS_CTRL:                  rdata <= ctrl;
        OFS_COMPARE_A:             rdata <= cmp_buf[0];
        OFS_COMPARE_A + CH_STRIDE: rdata <= cmp_buf[1];
        OFS_CAPTURE:               rdata <= capture_value;
        OFS_COUNTER:               rdata <= counter_value;
        OFS_FLAGS:                 rdata <= DATA_W'(flags);
        OFS_IRQ_EN:                rdata <= DATA_W'(irq_en);
        OFS_DIR:                   rdata <= DATA_W'(pin_direction_bit);
        default:                   rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// ==== tfpp_timer_asserts.sv ====
// Port-level checker for the PWM timer
`default_nettype none
module tfpp_timer_asserts
  import tfpp_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic [ADDR_W-1:0]    addr,
  input wire logic [DATA_W-1:0]    wdata,
  input wire logic                 wr_en,
  input wire logic                 rd_en,
  input wire logic [DATA_W-1:0]    rdata,
  input wire logic [NUM_CH-1:0]    pin_out,
  input wire logic [NUM_CH-1:0]    pin_oe,
  input wire logic [NUM_FLAGS-1:0] irq_req,
  input wire logic [NUM_FLAGS-1:0] irq_ack
);
  logic [3:0] mode;
  logic [2:0] cs;

  // Shadow of the mode and clock select fields
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= 4'h0;
      cs   <= 3'h0;
    end else if (wr_en && addr == OFS_CTRL) begin
      mode <= wdata[3:0];
      cs   <= wdata[6:4];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_idle_rdata: assert property (!rd_en |=> rdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (
    rd_en && addr == 8'h20 |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_mask_cmp: assert property (
    wr_en && addr == OFS_COMPARE_A && mode == WMS_FP8 ##2
    rd_en && addr == OFS_COMPARE_A |=> rdata[15:8] == 8'h00)
    else $error("compare bits above fixed top not masked");
  a_dir_oe: assert property (
    wr_en && addr == OFS_DIR |-> ##2 pin_oe == $past(wdata[1:0], 2))
    else $error("pin enable does not follow direction write");
  a_pin_gated: assert property (
    (pin_out & ~pin_oe & ~$past(pin_oe)) == 2'b00)
    else $error("pin driven while direction is input");
  a_ack_drop: assert property (
    |irq_ack |=> (irq_req & $past(irq_ack)) == 4'h0)
    else $error("request stays up after service");
  a_ien_off: assert property (
    wr_en && addr == OFS_IRQ_EN && wdata[3:0] == 4'h0 |=> ##1 irq_req == 4'h0)
    else $error("request without enable");
  a_stop_hold: assert property (
    (cs == CS_STOP && !wr_en) [*4] |=> $stable(pin_out))
    else $error("pin moved with timer stopped");
endmodule

bind tfpp_timer tfpp_timer_asserts tfpp_timer_asserts_inst (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
  .rd_en(rd_en), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe),
  .irq_req(irq_req), .irq_ack(irq_ack));
`default_nettype wire

// ==== tfpp_timer_tb.sv ====
// Self-checking bench for the PWM timer
`default_nettype none
module tfpp_timer_tb
  import tfpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk;
  logic                 rst_n;
  logic [ADDR_W-1:0]    addr;
  logic [DATA_W-1:0]    wdata;
  logic                 wr_en;
  logic                 rd_en;
  logic [DATA_W-1:0]    rdata;
  logic [NUM_CH-1:0]    pin_out;
  logic [NUM_CH-1:0]    pin_oe;
  logic [NUM_FLAGS-1:0] irq_req;
  logic [NUM_FLAGS-1:0] irq_ack;
  logic [31:0]          lfsr;
  int                   err_count;
  int                   num_checks;

  tfpp_timer tfpp_timer_inst (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq_req(irq_req),
    .irq_ack(irq_ack));

  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // One PWM setup, then high time of both pins over one period
  task automatic run(input logic [3:0] m, input logic [2:0] cs,
                     input logic [1:0] act, input logic [15:0] top,
                     input logic [15:0] raw, input logic rnd);
    logic [15:0] c;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] fm;
    logic        fx;
    logic        tp;
    int          p;
    int          h;
    int          dv;
    int          ha;
    int          hb;
    fx = m inside {WMS_PC8, WMS_PC9, WMS_PC10, WMS_FP8, WMS_FP9, WMS_FP10};
    tp = m == WMS_FP_CMPA || m == WMS_PC_CMPA;
    lfsr = next_rand(lfsr);
    if (rnd) raw = lfsr[15:0];
    if (!fx) raw = raw & top;
    c = raw & top;
    a = tp ? top : c;
    fm = 16'h0001 | (tp ? 16'h0002 : 16'h0000);
    if (m == WMS_FP_CAP || m == WMS_PC_CAP) fm = fm | 16'h0008;
    dv = cs == CS_DIV8 ? 8 : cs == CS_DIV64 ? 64 : cs == CS_DIV256 ? 256 :
         cs == CS_DIV1024 ? 1024 : 1;
    p = m[2] ? top + 1 : 2 * top;
    h = m[2] ? c + 1 : 2 * c;
    if (act == ACT_INV) h = p - h;
    if (act == ACT_TOGGLE) begin
      p = 2 * (top + 1);
      h = top + 1;
    end
    // Mode 0 first in compare A top modes so a stale compare A top is replaced at once; other modes go straight to m
    wr(OFS_CTRL, {4'h0, act, act, 4'h0, tp ? 4'h0 : m});
    repeat (6) @(posedge clk);
    wr(OFS_IRQ_EN, 16'h0000);
    wr(OFS_FLAGS, 16'h000F);
    wr(OFS_COUNTER, BOTTOM);
    wr(OFS_COMPARE_A, tp ? top : raw);
    rd(OFS_COMPARE_A, d);
    chk(d, a);
    wr(OFS_COMPARE_A + CH_STRIDE, raw);
    wr(OFS_CAPTURE, top);
    wr(OFS_DIR, 16'h0003);
    wr(OFS_IRQ_EN, 16'h0001);
    wr(OFS_CTRL, {4'h0, act, act, 1'b0, cs, m});
    repeat (3 * p * dv + (tp ? 2200 : 20)) @(posedge clk);
    ha = 0;
    hb = 0;
    repeat (p * dv) begin
      @(negedge clk);
      ha += int'(pin_out[0] === 1'b1);
      hb += int'(pin_out[1] === 1'b1);
    end
    chk(ha, (tp ? (act == ACT_INV ? 0 : p) : h) * dv);
    if (act != ACT_TOGGLE) begin
      chk(hb, h * dv);
    end else begin
      chk(hb % p, 0);
    end
    rd(OFS_FLAGS, d);
    chk(d & fm, fm);
    chk(irq_req[0], 1'b1);
    @(posedge clk);
    irq_ack <= 4'h1;
    @(posedge clk);
    irq_ack <= 4'h0;
    #1;
    chk(irq_req[0], 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #(90000 * 4);
    err_count++;
    end_of_test();
  end

  initial begin
    logic [15:0] d;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    irq_ack = 4'h0;
    err_count = 0;
    num_checks = 0;
    lfsr = 32'hA528;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_CTRL, d);
    chk(d, CTRL_RESET);
    rd(8'h20, d);
    chk(d, 16'h0000);
    run(WMS_FP8, CS_DIV1, ACT_NONINV, TOP_8, 16'h0000, 1'b1);
    run(WMS_FP8, CS_DIV1, ACT_INV, TOP_8, 16'h0000, 1'b0);
    run(WMS_FP8, CS_DIV1, ACT_NONINV, TOP_8, 16'hFFFF, 1'b0);
    run(WMS_FP9, CS_DIV1, ACT_NONINV, TOP_9, 16'h0000, 1'b1);
    run(WMS_FP10, CS_DIV1, ACT_INV, TOP_10, 16'h0000, 1'b1);
    run(WMS_FP8, CS_DIV8, ACT_NONINV, TOP_8, 16'h0000, 1'b1);
    run(WMS_FP8, CS_DIV1, ACT_TOGGLE, TOP_8, 16'h0000, 1'b1);
    run(WMS_FP_CAP, CS_DIV1, ACT_NONINV, 16'h0003, 16'h0001, 1'b0);
    run(WMS_FP_CMPA, CS_DIV1, ACT_INV, 16'h003F, 16'h0000, 1'b1);
    run(WMS_PC8, CS_DIV1, ACT_NONINV, TOP_8, 16'h0000, 1'b1);
    run(WMS_PC9, CS_DIV1, ACT_INV, TOP_9, 16'h0000, 1'b1);
    run(WMS_PC10, CS_DIV1, ACT_NONINV, TOP_10, 16'hFFFF, 1'b0);
    run(WMS_PC_CAP, CS_DIV1, ACT_NONINV, 16'h007F, 16'h0000, 1'b0);
    run(WMS_PC_CMPA, CS_DIV1, ACT_INV, 16'h001F, 16'h0000, 1'b1);
    for (int i = 3; i <= 5; i++) begin
      run(WMS_FP_CAP, 3'(i), ACT_NONINV, 16'h0003, 16'h0002, 1'b0);
    end
    wr(OFS_CTRL, {8'h00, 4'h0, WMS_FP_CAP});
    repeat (6) @(posedge clk);
    wr(OFS_COUNTER, 16'h0100);
    wr(OFS_CAPTURE, 16'h0010);
    wr(OFS_CTRL, {8'h00, 1'b0, CS_DIV1, WMS_FP_CAP});
    repeat (40) @(posedge clk);
    rd(OFS_COUNTER, d);
    chk(d > 16'h0120, 1'b1);
    wr(OFS_DIR, 16'h0000);
    repeat (3) @(posedge clk);
    chk({pin_oe, pin_out}, 4'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
